// File: include/nbwp_defines.svh
`ifndef NBWP_DEFINES_SVH
`define NBWP_DEFINES_SVH

// ----------------------------------------------------------------
// Feature commands and addresses
// ----------------------------------------------------------------
`define NBWP_CMD_FEATURE_READ  8'h0F
`define NBWP_CMD_FEATURE_WRITE 8'h1F
`define NBWP_ADDR_GUARD        8'hA0
`define NBWP_ADDR_CONFIG       8'hB0

// ----------------------------------------------------------------
// Protection register fields
// ----------------------------------------------------------------
`define NBWP_BIT_SEL_HI        7
`define NBWP_RANGE_MSB         6
`define NBWP_RANGE_LSB         3
`define NBWP_BIT_TOP_BOTTOM    2
`define NBWP_BIT_PIN_ENABLE    1
`define NBWP_BIT_SEL_LO        0
`define NBWP_GUARD_RESET       8'h7C

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define NBWP_BIT_REG_LOCK      5

// ----------------------------------------------------------------
// Range decoding
// ----------------------------------------------------------------
`define NBWP_BLOCK_ADDR_W      10
`define NBWP_RANGE_MAX_FRAC    4'h9

`endif

// File: include/nbwp_pkg.sv
package nbwp_pkg;

	typedef enum logic [1:0] {
		NBWP_GUARD_OPEN,
		NBWP_GUARD_PIN_GATED,
		NBWP_GUARD_FROZEN,
		NBWP_GUARD_READ_ONLY
	} nbwp_guard_state_t;

endpackage

// File: rtl/nbwp_block_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "nbwp_defines.svh"

// Notes on behaviour
// - All protection register bits volatile, rewritable by feature write.
// - Pin enable and both select bits zero: pin is only a data line.
// - Select high only, pin enable zero, pin low: register writes refused.
// - Same setting with pin high: register writes accepted, pin stays data line.
// - Select low only: register frozen until power cycle, whatever pin enable.
// - Both select bits one: lock bit settable, then register frozen.
// - Pin enable zero: quad transfers allowed.
// - Pin enable one: no quad transfers; pin is write protect input.
// - Pin enable one and pin low: every write blocked, device read-only.
// - Power cycle turns select low only into both select bits zero.
// - Top select zero: codes 1..9 lock upper 1/512..1/2, 101x/11xx all.
// - Top select one: codes 1..9 lock lower 1/512..1/2.
// - Program or erase into a locked block is ignored.
// - Such program sets program fail; such erase sets erase fail.
// - Feature read 0Fh and write 1Fh, each with one address byte.
// - Lock bit is configuration bit 5, freezes register until power cycle.
module nbwp_block_guard (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [7:0] cmd_opcode_i,
	input  wire logic [7:0] feat_addr_i,
	input  wire logic [7:0] feat_wdata_i,
	input  wire logic       data_line_two_i,
	input  wire logic       op_valid_i,
	input  wire logic       op_is_erase_i,
	input  wire logic       op_addr_valid_i,
	input  wire logic [9:0] op_block_i,
	output logic [7:0]      rdata_o,
	output logic            rdata_valid_o,
	output logic            wr_refused_o,
	output logic            op_accept_o,
	output logic            op_done_o,
	output logic            program_fail_o,
	output logic            erase_fail_o,
	output logic            quad_enable_o,
	output logic            device_read_only_o,
	output logic            guard_reg_lock_o,
	output logic [7:0]      block_lock_config_o
);

	// ----------------------------------------------------------------
	// Pin synchroniser, three stages
	// ----------------------------------------------------------------
	// Reset to idle high: no false read-only after reset
	logic [2:0] pin_sync;
	logic       pin_level;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_sync <= 3'h7;
		end else begin
			pin_sync <= {pin_sync[1:0], data_line_two_i};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_level <= 1'b1;
		end else if (pin_sync[2] == pin_sync[1]) begin
			pin_level <= pin_sync[2];
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] block_lock_config;
	logic       guard_reg_lock;

	wire reg_guard_sel_hi  = block_lock_config[`NBWP_BIT_SEL_HI];
	wire reg_guard_sel_lo  = block_lock_config[`NBWP_BIT_SEL_LO];
	wire guard_pin_enable  = block_lock_config[`NBWP_BIT_PIN_ENABLE];
	wire top_bottom_select = block_lock_config[`NBWP_BIT_TOP_BOTTOM];
	wire [3:0] lock_range_code = block_lock_config[`NBWP_RANGE_MSB:`NBWP_RANGE_LSB];

	// ----------------------------------------------------------------
	// Guard state
	// ----------------------------------------------------------------
	nbwp_pkg::nbwp_guard_state_t guard_state;

	wire read_only  = guard_pin_enable && !pin_level;
	wire pin_gated  = reg_guard_sel_hi && !reg_guard_sel_lo &&
		!guard_pin_enable && !pin_level;
	wire power_down = reg_guard_sel_lo && !reg_guard_sel_hi;
	wire frozen     = power_down || guard_reg_lock;

	// Read-only outranks frozen and pin-gated states
	always_comb begin
		if (read_only) begin
			guard_state = nbwp_pkg::NBWP_GUARD_READ_ONLY;
		end else if (frozen) begin
			guard_state = nbwp_pkg::NBWP_GUARD_FROZEN;
		end else if (pin_gated) begin
			guard_state = nbwp_pkg::NBWP_GUARD_PIN_GATED;
		end else begin
			guard_state = nbwp_pkg::NBWP_GUARD_OPEN;
		end
	end

	// ----------------------------------------------------------------
	// Feature command decode
	// ----------------------------------------------------------------
	wire is_read     = cmd_valid_i && (cmd_opcode_i == `NBWP_CMD_FEATURE_READ);
	wire is_write    = cmd_valid_i && (cmd_opcode_i == `NBWP_CMD_FEATURE_WRITE);
	wire hit_guard   = (feat_addr_i == `NBWP_ADDR_GUARD);
	wire hit_config  = (feat_addr_i == `NBWP_ADDR_CONFIG);
	wire guard_open  = (guard_state == nbwp_pkg::NBWP_GUARD_OPEN);
	wire lock_allow  = reg_guard_sel_hi && reg_guard_sel_lo && !read_only;
	wire wr_guard    = is_write && hit_guard && guard_open;
	wire wr_lock     = is_write && hit_config && lock_allow &&
		feat_wdata_i[`NBWP_BIT_REG_LOCK];
	wire refuse      = is_write && ((hit_guard && !guard_open) ||
		(hit_config && read_only));
	wire [7:0] config_view = {2'h0, guard_reg_lock, 5'h00};

	logic [7:0] next_rdata;

	always_comb begin
		if (hit_guard) begin
			next_rdata = block_lock_config;
		end else if (hit_config) begin
			next_rdata = config_view;
		end else begin
			next_rdata = 8'h00;
		end
	end

	// Reset stands for power-up, clearing any power lock-down
	// No clear path for the lock: only reset drops it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			block_lock_config <= `NBWP_GUARD_RESET;
			guard_reg_lock    <= 1'b0;
		end else begin
			if (wr_guard) begin
				block_lock_config <= feat_wdata_i;
			end
			if (wr_lock) begin
				guard_reg_lock <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o       <= 8'h00;
			rdata_valid_o <= 1'b0;
			wr_refused_o  <= 1'b0;
		end else begin
			rdata_valid_o <= is_read;
			wr_refused_o  <= refuse;
			if (is_read) begin
				rdata_o <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Program and erase screening
	// ----------------------------------------------------------------
	logic range_hit;

	nbwp_range_decode #(
		.BLOCK_ADDR_W(`NBWP_BLOCK_ADDR_W)
	) u_range (
		.lock_range_code_i  (lock_range_code),
		.top_bottom_select_i(top_bottom_select),
		.block_i            (op_block_i),
		.hit_o              (range_hit)
	);

	wire op_blocked     = range_hit || read_only || !op_addr_valid_i;
	// Erase fail has no address-valid qualifier
	wire erase_blocked  = range_hit || read_only;
	wire next_op_accept = op_valid_i && !op_blocked;

	// Fail flags follow the latest op of their kind
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_accept_o    <= 1'b0;
			op_done_o      <= 1'b0;
			program_fail_o <= 1'b0;
			erase_fail_o   <= 1'b0;
		end else begin
			op_done_o   <= op_valid_i;
			op_accept_o <= next_op_accept;
			if (op_valid_i && !op_is_erase_i) begin
				program_fail_o <= op_blocked;
			end
			if (op_valid_i && op_is_erase_i) begin
				erase_fail_o <= erase_blocked;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin role and status outputs
	// ----------------------------------------------------------------
	wire next_quad_enable = !guard_pin_enable;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			quad_enable_o       <= 1'b1;
			device_read_only_o  <= 1'b0;
			guard_reg_lock_o    <= 1'b0;
			block_lock_config_o <= `NBWP_GUARD_RESET;
		end else begin
			quad_enable_o       <= next_quad_enable;
			device_read_only_o  <= read_only;
			guard_reg_lock_o    <= guard_reg_lock;
			block_lock_config_o <= block_lock_config;
		end
	end

endmodule

`default_nettype wire

// File: rtl/nbwp_range_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "nbwp_defines.svh"

module nbwp_range_decode #(
	parameter int BLOCK_ADDR_W = `NBWP_BLOCK_ADDR_W
) (
	input  wire logic [3:0]              lock_range_code_i,
	input  wire logic                    top_bottom_select_i,
	input  wire logic [BLOCK_ADDR_W-1:0] block_i,
	output logic                         hit_o
);

	generate
		if (BLOCK_ADDR_W != `NBWP_BLOCK_ADDR_W) begin : g_bad_width
			$error("nbwp_range_decode serves exactly 1024 blocks");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Fraction decode: code n of 1..9 locks 2**n blocks at one end
	// ----------------------------------------------------------------
	logic [BLOCK_ADDR_W-1:0] high_mask;
	logic [BLOCK_ADDR_W-1:0] masked;
	logic                    none_locked;
	logic                    all_locked;
	logic                    upper_hit;
	logic                    lower_hit;

	assign high_mask   = {BLOCK_ADDR_W{1'b1}} << lock_range_code_i;
	assign masked      = block_i & high_mask;
	assign none_locked = (lock_range_code_i == 4'h0);
	assign all_locked  = (lock_range_code_i > `NBWP_RANGE_MAX_FRAC);
	assign upper_hit   = (masked == high_mask);
	assign lower_hit   = (masked == {BLOCK_ADDR_W{1'b0}});

	assign hit_o = !none_locked &&
		(all_locked || (top_bottom_select_i ? lower_hit : upper_hit));

endmodule

`default_nettype wire

// File: verif/nbwp_block_guard_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Port checker
// ----------------
module nbwp_block_guard_chk (
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic       cmd_valid_i,
	input wire logic [7:0] cmd_opcode_i,
	input wire logic [7:0] feat_addr_i,
	input wire logic [7:0] feat_wdata_i,
	input wire logic       op_valid_i,
	input wire logic       op_is_erase_i,
	input wire logic       op_addr_valid_i,
	input wire logic [9:0] op_block_i,
	input wire logic [7:0] rdata_o,
	input wire logic       rdata_valid_o,
	input wire logic       wr_refused_o,
	input wire logic       op_accept_o,
	input wire logic       program_fail_o,
	input wire logic       erase_fail_o,
	input wire logic       quad_enable_o,
	input wire logic       guard_reg_lock_o,
	input wire logic [7:0] block_lock_config_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	wire logic wr_cmd = cmd_valid_i && cmd_opcode_i == 8'h1F;
	wire logic rd_a0 = cmd_valid_i && cmd_opcode_i == 8'h0F && feat_addr_i == 8'hA0;
	wire logic open_cfg = block_lock_config_o[7] == 1'h0 && block_lock_config_o[1:0] == 2'h0;
	a_read_answer: assert property (rd_a0 |=> rdata_valid_o)
		else $error("read not answered");
	a_read_value: assert property (rd_a0 && !$past(cmd_valid_i)
		|=> rdata_o == $past(block_lock_config_o)) else $error("read data wrong");
	a_open_write: assert property (wr_cmd && feat_addr_i == 8'hA0 && open_cfg
		&& !guard_reg_lock_o && !$past(cmd_valid_i)
		|-> ##2 block_lock_config_o == $past(feat_wdata_i, 2)) else $error("write lost");
	a_frozen_hold: assert property (guard_reg_lock_o |=> $stable(block_lock_config_o))
		else $error("locked register changed");
	a_quad_pin: assert property ($stable(block_lock_config_o[1]) [*2]
		|-> quad_enable_o == !block_lock_config_o[1]) else $error("quad enable wrong");
	a_upper_lock: assert property (op_valid_i && op_block_i[9:1] == 9'h1FF
		&& block_lock_config_o[6:2] == 5'h02 && !$past(cmd_valid_i)
		|=> !op_accept_o && (program_fail_o || erase_fail_o)) else $error("top block open");
	a_invalid_prog: assert property (op_valid_i && !op_is_erase_i && !op_addr_valid_i
		|=> program_fail_o && !op_accept_o) else $error("invalid program passed");
	a_refused_cause: assert property (wr_refused_o |-> $past(wr_cmd))
		else $error("refusal without write");
	c_lock: cover property (guard_reg_lock_o);
	c_refused: cover property (wr_refused_o);
	c_op_blocked: cover property (op_valid_i ##1 !op_accept_o);
endmodule
bind nbwp_block_guard nbwp_block_guard_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.cmd_valid_i(cmd_valid_i), .cmd_opcode_i(cmd_opcode_i), .feat_addr_i(feat_addr_i),
	.feat_wdata_i(feat_wdata_i), .op_valid_i(op_valid_i), .op_is_erase_i(op_is_erase_i),
	.op_addr_valid_i(op_addr_valid_i), .op_block_i(op_block_i), .rdata_o(rdata_o),
	.rdata_valid_o(rdata_valid_o), .wr_refused_o(wr_refused_o), .op_accept_o(op_accept_o),
	.program_fail_o(program_fail_o), .erase_fail_o(erase_fail_o),
	.quad_enable_o(quad_enable_o), .guard_reg_lock_o(guard_reg_lock_o),
	.block_lock_config_o(block_lock_config_o));
`default_nettype wire

// File: verif/nbwp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Feature host
// ----------------
module nbwp_host_model (
	input  wire logic       clk_i,
	output var  logic       cmd_valid_o,
	output var  logic [7:0] cmd_opcode_o,
	output var  logic [7:0] feat_addr_o,
	output var  logic [7:0] feat_wdata_o
);
	initial begin
		cmd_valid_o = 1'h0;
		cmd_opcode_o = 8'h00;
		feat_addr_o = 8'h00;
		feat_wdata_o = 8'h00;
	end
	task automatic xfer(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cmd_valid_o <= 1'h1;
		cmd_opcode_o <= op;
		feat_addr_o <= a;
		feat_wdata_o <= d;
		@(posedge clk_i);
		cmd_valid_o <= 1'h0;
		cmd_opcode_o <= ~op;
		feat_addr_o <= ~a;
		feat_wdata_o <= ~d;
	endtask
	// Settings first, then both select bits, then the lock
	task automatic lock_down(input logic [7:0] cfg);
		xfer(8'h1F, 8'hA0, cfg & 8'h7E);
		xfer(8'h1F, 8'hA0, cfg | 8'h81);
		xfer(8'h1F, 8'hB0, 8'h20);
	endtask
endmodule
`default_nettype wire

// File: verif/tb_nbwp_block_guard.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Bench
// ----------------
module tb_nbwp_block_guard;
	logic       clk_i = 1'h0;
	logic       arst_n_i = 1'h0;
	logic       data_line_two_i = 1'h1;
	logic       op_valid_i = 1'h0;
	logic       op_is_erase_i = 1'h0;
	logic       op_addr_valid_i = 1'h1;
	logic [9:0] op_block_i = 10'h000;
	wire  logic       cmd_valid_i;
	wire  logic [7:0] cmd_opcode_i, feat_addr_i, feat_wdata_i, rdata_o, block_lock_config_o;
	wire  logic       rdata_valid_o, wr_refused_o, op_accept_o, op_done_o, program_fail_o;
	wire  logic       erase_fail_o, quad_enable_o, device_read_only_o, guard_reg_lock_o;
	logic [7:0] cur = 8'h7C;
	int         n_mismatch = 0;
	int         samples_checked = 0;
	int         n;
	logic [9:0] b;
	nbwp_host_model host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_opcode_o(cmd_opcode_i),
		.feat_addr_o(feat_addr_i), .feat_wdata_o(feat_wdata_i));
	nbwp_block_guard dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_opcode_i(cmd_opcode_i), .feat_addr_i(feat_addr_i), .feat_wdata_i(feat_wdata_i),
		.data_line_two_i(data_line_two_i), .op_valid_i(op_valid_i),
		.op_is_erase_i(op_is_erase_i), .op_addr_valid_i(op_addr_valid_i),
		.op_block_i(op_block_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
		.wr_refused_o(wr_refused_o), .op_accept_o(op_accept_o), .op_done_o(op_done_o),
		.program_fail_o(program_fail_o), .erase_fail_o(erase_fail_o),
		.quad_enable_o(quad_enable_o), .device_read_only_o(device_read_only_o),
		.guard_reg_lock_o(guard_reg_lock_o), .block_lock_config_o(block_lock_config_o));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.xfer(8'h0F, a, 8'h00);
		#1;
		chk("rdata_valid", 10'h001, rdata_valid_o);
		chk("rdata", e, rdata_o);
		if (a == 8'hA0)
			chk("copy", e, block_lock_config_o);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
		host.xfer(8'h1F, a, d);
		#1;
		chk("wr_refused", r, wr_refused_o);
		if (a == 8'hA0 && !r)
			cur = d;
		rd(8'hA0, cur);
	endtask
	task automatic op(input logic er, input logic av, input logic [9:0] blk, input logic e);
		@(posedge clk_i);
		op_valid_i <= 1'h1;
		op_is_erase_i <= er;
		op_addr_valid_i <= av;
		op_block_i <= blk;
		@(posedge clk_i);
		op_valid_i <= 1'h0;
		#1;
		chk("op_done", 10'h001, op_done_o);
		chk("op_accept", !e, op_accept_o);
		chk("fail", e, er ? erase_fail_o : program_fail_o);
	endtask
	task automatic pin_set(input logic v);
		@(posedge clk_i);
		data_line_two_i <= v;
		repeat (6) @(posedge clk_i);
		#1;
	endtask
	task automatic rst();
		@(posedge clk_i);
		arst_n_i <= 1'h0;
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'h1;
		cur = 8'h7C;
	endtask
	function automatic logic locked(input logic [4:0] c, input logic [9:0] blk);
		if (c[4:1] == 4'h0)
			return 1'h0;
		if (c[4:1] > 4'h9)
			return 1'h1;
		return c[0] ? (blk < (10'h001 << c[4:1])) : (blk >= 11'h400 - (11'h001 << c[4:1]));
	endfunction
	task automatic finish_test();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8000) @(posedge clk_i);
		n_mismatch++;
		finish_test();
	end
	initial begin
		rst();
		rd(8'hA0, 8'h7C);
		for (int c = 0; c < 32; c++) begin
			wr(8'hA0, 8'(c << 2), 1'h0);
			n = 1 << ((c >> 1) > 9 ? 9 : (c >> 1));
			for (int k = 0; k < 4; k++) begin
				b = k[1] ? 10'(1023 - n + k[0]) : 10'(n - 1 + k[0]);
				op(k[0], 1'h1, b, locked(5'(c), b));
			end
		end
		wr(8'hA0, 8'h00, 1'h0);
		op(1'h0, 1'h0, 10'h005, 1'h1);
		pin_set(1'h0);
		chk("quad", 10'h001, quad_enable_o);
		wr(8'hA0, 8'h02, 1'h0);
		chk("quad", 10'h000, quad_enable_o);
		chk("read_only", 10'h001, device_read_only_o);
		wr(8'hA0, 8'h00, 1'h1);
		op(1'h1, 1'h1, 10'h100, 1'h1);
		pin_set(1'h1);
		wr(8'hA0, 8'h80, 1'h0);
		pin_set(1'h0);
		wr(8'hA0, 8'h00, 1'h1);
		pin_set(1'h1);
		wr(8'hA0, 8'h01, 1'h0);
		wr(8'hA0, 8'h00, 1'h1);
		rst();
		rd(8'hA0, 8'h7C);
		wr(8'hA0, 8'h00, 1'h0);
		host.lock_down(8'h08);
		cur = 8'h89;
		rd(8'hB0, 8'h20);
		chk("lock", 10'h001, guard_reg_lock_o);
		wr(8'hA0, 8'h00, 1'h1);
		finish_test();
	end
endmodule
`default_nettype wire
